// [hw/mcpr_pkg.sv]
package mcpr_pkg;
    localparam int          ADDR_W            = 16;
    localparam int          DATA_W            = 32;
    localparam int          PEAK_W            = 24;
    localparam int          TRIM_W            = 10;
    localparam int          PEAK_TAG_LSB      = 24;
    localparam int          PEAK_TAG_W        = 3;

    localparam logic [15:0] ADDR_HPF_BYPASS   = 16'h43B6;
    localparam logic [15:0] ADDR_CURRENT_PEAK_CAPTURE        = 16'hE500;
    localparam logic [15:0] ADDR_CF1_DIV      = 16'hE611;
    localparam logic [15:0] ADDR_CF2_DIV      = 16'hE612;
    localparam logic [15:0] ADDR_CF3_DIV      = 16'hE613;
    localparam logic [15:0] ADDR_TRIM_A       = 16'hE614;
    localparam logic [15:0] ADDR_TRIM_B       = 16'hE615;
    localparam logic [15:0] ADDR_TRIM_C       = 16'hE616;
    localparam logic [15:0] ADDR_SIGN         = 16'hE617;
    localparam logic [15:0] ADDR_GEN_SETUP    = 16'hE618;
    localparam logic [15:0] ADDR_MEAS_SETUP   = 16'hE700;
    localparam logic [15:0] ADDR_ACC_SETUP    = 16'hE701;
    localparam logic [15:0] ADDR_LINE_ACC     = 16'hE702;
    localparam logic [15:0] ADDR_PEAK_WIN     = 16'hE703;
    localparam logic [15:0] ADDR_DIP_WIN      = 16'hE704;
    localparam logic [15:0] ADDR_PULSE_LATCH  = 16'hE705;
    localparam logic [15:0] ADDR_FAST_CAP     = 16'hE706;
    localparam logic [15:0] ADDR_REVISION     = 16'hE707;
    localparam logic [15:0] ADDR_PIN_SLOT     = 16'hEBFF;
    localparam logic [15:0] ADDR_LP_OC_LVL    = 16'hEC00;
    localparam logic [15:0] ADDR_LP1_SETUP    = 16'hEC01;

    localparam logic [23:0] RST_HPF_BYPASS    = 24'h000000;
    localparam logic [15:0] RST_CF_DIV        = 16'h0000;
    localparam logic [9:0]  RST_TRIM          = 10'h000;
    localparam logic [15:0] RST_GEN_SETUP     = 16'h0000;
    localparam logic [7:0]  RST_MEAS_SETUP    = 8'h1C;
    localparam logic [7:0]  RST_ACC_SETUP     = 8'h00;
    localparam logic [7:0]  RST_LINE_ACC      = 8'h78;
    localparam logic [7:0]  RST_PEAK_WIN      = 8'h00;
    localparam logic [7:0]  RST_DIP_WIN       = 8'h00;
    localparam logic [7:0]  RST_PULSE_LATCH   = 8'h01;
    localparam logic [7:0]  RST_FAST_CAP      = 8'h00;
    localparam logic [7:0]  RST_LP_OC_LVL     = 8'h07;
    localparam logic [7:0]  RST_LP1_SETUP     = 8'h00;
    // arbitrary value
    localparam logic [7:0]  DIE_REVISION      = 8'h5A;
endpackage

// [hw/mcpr_peak_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface mcpr_peak_if;
    logic [23:0] mag_a;
    logic [23:0] mag_b;
    logic [23:0] mag_c;
    logic        sample_valid;
    logic        half_cycle;
    logic [7:0]  window;
    logic [23:0] peak_value;
    logic [2:0]  peak_phase;
    logic        peak_update;
    modport cap (input mag_a, mag_b, mag_c, sample_valid, half_cycle, window,
                 output peak_value, peak_phase, peak_update);
    modport ctl (output mag_a, mag_b, mag_c, sample_valid, half_cycle, window,
                 input peak_value, peak_phase, peak_update);
endinterface
`default_nettype wire

// [hw/mcpr_cfg_reg.sv]
`timescale 1ns/1ps
`default_nettype none
module mcpr_cfg_reg #(
    parameter int             W   = 8,
    parameter logic [W-1:0]   RST = '0
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rst_n,
    // write side
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wr_data,
    // stored value
    output logic [W-1:0]      q
);
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    assign q_nxt = wr_en ? wr_data : q_r;
    assign q     = q_r;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            q_r <= RST;
        end else begin
            q_r <= q_nxt;
        end
    end
endmodule
`default_nettype wire

// [hw/mcpr_peak_capture.sv]
`timescale 1ns/1ps
`default_nettype none
module mcpr_peak_capture (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // samples and window
    mcpr_peak_if.cap  pk
);
    logic [23:0] run_max_r;
    logic [2:0]  run_ph_r;
    logic [7:0]  cnt_r;
    logic [23:0] out_val_r;
    logic [2:0]  out_ph_r;
    logic        upd_r;

    logic [23:0] ab_max;
    logic [23:0] smp_max;
    logic [2:0]  smp_ph;
    logic        smp_bigger;
    logic        smp_equal;
    logic [7:0]  cnt_inc;
    logic        win_done;
    logic [23:0] cur_max;
    logic [2:0]  cur_ph;

    assign ab_max     = (pk.mag_a >= pk.mag_b) ? pk.mag_a : pk.mag_b;
    assign smp_max    = (ab_max >= pk.mag_c) ? ab_max : pk.mag_c;
    // every phase reaching the maximum is tagged
    assign smp_ph     = {pk.mag_c == smp_max, pk.mag_b == smp_max, pk.mag_a == smp_max};
    assign smp_bigger = pk.sample_valid && (smp_max > run_max_r);
    assign smp_equal  = pk.sample_valid && (smp_max == run_max_r) && (smp_max != 24'h000000);
    assign cur_max    = smp_bigger ? smp_max : run_max_r;
    assign cur_ph     = smp_bigger ? smp_ph : (smp_equal ? (run_ph_r | smp_ph) : run_ph_r);
    assign cnt_inc    = cnt_r + 8'h01;
    // a zero window never closes, so the last capture stays
    assign win_done   = pk.half_cycle && (pk.window != 8'h00) && (cnt_inc >= pk.window);

    assign pk.peak_value  = out_val_r;
    assign pk.peak_phase  = out_ph_r;
    assign pk.peak_update = upd_r;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            run_max_r <= 24'h000000;
            run_ph_r  <= 3'h0;
            cnt_r     <= 8'h00;
            out_val_r <= 24'h000000;
            out_ph_r  <= 3'h0;
            upd_r     <= 1'b0;
        end else begin
            upd_r <= win_done;
            if (win_done) begin
                out_val_r <= cur_max;
                out_ph_r  <= cur_ph;
                run_max_r <= 24'h000000;
                run_ph_r  <= 3'h0;
                cnt_r     <= 8'h00;
            end else begin
                run_max_r <= cur_max;
                run_ph_r  <= cur_ph;
                if (pk.half_cycle) begin
                    cnt_r <= cnt_inc;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [hw/mcpr_regbank.sv]
`timescale 1ns/1ps
`default_nettype none
module mcpr_regbank (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // register access port
    input  wire logic [15:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [31:0] reg_wdata,
    output logic [31:0]      reg_rdata,
    output logic             reg_rvalid,
    // measurement inputs
    input  wire logic [23:0] cur_mag_a,
    input  wire logic [23:0] cur_mag_b,
    input  wire logic [23:0] cur_mag_c,
    input  wire logic        cur_sample_valid,
    input  wire logic        half_line_cycle,
    input  wire logic [15:0] power_sign_in,
    // serial port state
    input  wire logic        spi_active,
    // select or capture pin
    output logic             select_or_capture_pin_o,
    output logic             select_or_capture_pin_oe,
    // settings to the signal path
    output logic             highpass_bypass_en,
    output logic [15:0]      pulse_out1_divider,
    output logic [15:0]      pulse_out2_divider,
    output logic [15:0]      pulse_out3_divider,
    output logic [9:0]       phase_a_delay_trim,
    output logic [9:0]       phase_b_delay_trim,
    output logic [9:0]       phase_c_delay_trim,
    output logic [15:0]      general_setup,
    output logic [7:0]       measurement_setup,
    output logic [7:0]       accumulation_setup,
    output logic [7:0]       line_accum_behavior,
    output logic [7:0]       peak_window_halfcycles,
    output logic [7:0]       dip_window_halfcycles,
    output logic [7:0]       pulses_per_energy_latch,
    output logic [7:0]       fast_capture_port_setup,
    output logic [7:0]       lowpower_overcurrent_level,
    output logic [7:0]       lowpower1_setup
);
    mcpr_peak_if pk ();

    // write strobes
    logic        we_hpf;
    logic        we_cf1;
    logic        we_cf2;
    logic        we_cf3;
    logic        we_trim_a;
    logic        we_trim_b;
    logic        we_trim_c;
    logic        we_gen;
    logic        we_meas;
    logic        we_acc;
    logic        we_line;
    logic        we_pkwin;
    logic        we_dipwin;
    logic        we_plat;
    logic        we_fcap;
    logic        we_lpoc;
    logic        we_lp1;
    logic        we_pin;

    // stored values
    logic [23:0] hpf_q;
    logic [15:0] cf1_q;
    logic [15:0] cf2_q;
    logic [15:0] cf3_q;
    logic [9:0]  trim_a_q;
    logic [9:0]  trim_b_q;
    logic [9:0]  trim_c_q;
    logic [15:0] gen_q;
    logic [7:0]  meas_q;
    logic [7:0]  acc_q;
    logic [7:0]  line_q;
    logic [7:0]  pkwin_q;
    logic [7:0]  dipwin_q;
    logic [7:0]  plat_q;
    logic [7:0]  fcap_q;
    logic [7:0]  lpoc_q;
    logic [7:0]  lp1_q;

    // read-only state, pin-slot state and read-port registers
    logic [23:0] current_peak_capture_val_r;
    logic [2:0]  current_peak_capture_ph_r;
    logic [15:0] sign_r;
    logic        pin_r;
    logic        pin_oe_r;
    logic        hpf_byp_r;
    logic [31:0] rdata_r;
    logic        rvalid_r;
    logic [31:0] rdata_nxt;
    logic        pin_nxt;

    assign we_hpf    = reg_wr && (reg_addr == mcpr_pkg::ADDR_HPF_BYPASS);
    assign we_cf1    = reg_wr && (reg_addr == mcpr_pkg::ADDR_CF1_DIV);
    assign we_cf2    = reg_wr && (reg_addr == mcpr_pkg::ADDR_CF2_DIV);
    assign we_cf3    = reg_wr && (reg_addr == mcpr_pkg::ADDR_CF3_DIV);
    assign we_trim_a = reg_wr && (reg_addr == mcpr_pkg::ADDR_TRIM_A);
    assign we_trim_b = reg_wr && (reg_addr == mcpr_pkg::ADDR_TRIM_B);
    assign we_trim_c = reg_wr && (reg_addr == mcpr_pkg::ADDR_TRIM_C);
    assign we_gen    = reg_wr && (reg_addr == mcpr_pkg::ADDR_GEN_SETUP);
    assign we_meas   = reg_wr && (reg_addr == mcpr_pkg::ADDR_MEAS_SETUP);
    assign we_acc    = reg_wr && (reg_addr == mcpr_pkg::ADDR_ACC_SETUP);
    assign we_line   = reg_wr && (reg_addr == mcpr_pkg::ADDR_LINE_ACC);
    assign we_pkwin  = reg_wr && (reg_addr == mcpr_pkg::ADDR_PEAK_WIN);
    assign we_dipwin = reg_wr && (reg_addr == mcpr_pkg::ADDR_DIP_WIN);
    assign we_plat   = reg_wr && (reg_addr == mcpr_pkg::ADDR_PULSE_LATCH);
    assign we_fcap   = reg_wr && (reg_addr == mcpr_pkg::ADDR_FAST_CAP);
    assign we_lpoc   = reg_wr && (reg_addr == mcpr_pkg::ADDR_LP_OC_LVL);
    assign we_lp1    = reg_wr && (reg_addr == mcpr_pkg::ADDR_LP1_SETUP);
    // pin slot only acts while the SPI port is the active one
    assign we_pin    = reg_wr && spi_active && (reg_addr == mcpr_pkg::ADDR_PIN_SLOT);
    assign pin_nxt   = we_pin ? reg_wdata[0] : pin_r;

    mcpr_cfg_reg #(.W(24), .RST(mcpr_pkg::RST_HPF_BYPASS)) u_hpf (
        .mclk(mclk), .rst_n(rst_n), .wr_en(we_hpf), .wr_data(reg_wdata[23:0]), .q(hpf_q));
    mcpr_cfg_reg #(.W(16), .RST(mcpr_pkg::RST_CF_DIV)) u_cf1 (
        .mclk(mclk), .rst_n(rst_n), .wr_en(we_cf1), .wr_data(reg_wdata[15:0]), .q(cf1_q));
    mcpr_cfg_reg #(.W(16), .RST(mcpr_pkg::RST_CF_DIV)) u_cf2 (
        .mclk(mclk), .rst_n(rst_n), .wr_en(we_cf2), .wr_data(reg_wdata[15:0]), .q(cf2_q));
    mcpr_cfg_reg #(.W(16), .RST(mcpr_pkg::RST_CF_DIV)) u_cf3 (
        .mclk(mclk), .rst_n(rst_n), .wr_en(we_cf3), .wr_data(reg_wdata[15:0]), .q(cf3_q));
    // only the low ten bits are kept; upper bits of the word are dropped
    mcpr_cfg_reg #(.W(10), .RST(mcpr_pkg::RST_TRIM)) u_trim_a (
        .mclk(mclk), .rst_n(rst_n), .wr_en(we_trim_a), .wr_data(reg_wdata[9:0]), .q(trim_a_q));
    mcpr_cfg_reg #(.W(10), .RST(mcpr_pkg::RST_TRIM)) u_trim_b (
        .mclk(mclk), .rst_n(rst_n), .wr_en(we_trim_b), .wr_data(reg_wdata[9:0]), .q(trim_b_q));
    mcpr_cfg_reg #(.W(10), .RST(mcpr_pkg::RST_TRIM)) u_trim_c (
        .mclk(mclk), .rst_n(rst_n), .wr_en(we_trim_c), .wr_data(reg_wdata[9:0]), .q(trim_c_q));
    mcpr_cfg_reg #(.W(16), .RST(mcpr_pkg::RST_GEN_SETUP)) u_gen (
        .mclk(mclk), .rst_n(rst_n), .wr_en(we_gen), .wr_data(reg_wdata[15:0]), .q(gen_q));
    mcpr_cfg_reg #(.W(8), .RST(mcpr_pkg::RST_MEAS_SETUP)) u_meas (
        .mclk(mclk), .rst_n(rst_n), .wr_en(we_meas), .wr_data(reg_wdata[7:0]), .q(meas_q));
    mcpr_cfg_reg #(.W(8), .RST(mcpr_pkg::RST_ACC_SETUP)) u_acc (
        .mclk(mclk), .rst_n(rst_n), .wr_en(we_acc), .wr_data(reg_wdata[7:0]), .q(acc_q));
    mcpr_cfg_reg #(.W(8), .RST(mcpr_pkg::RST_LINE_ACC)) u_line (
        .mclk(mclk), .rst_n(rst_n), .wr_en(we_line), .wr_data(reg_wdata[7:0]), .q(line_q));
    mcpr_cfg_reg #(.W(8), .RST(mcpr_pkg::RST_PEAK_WIN)) u_pkwin (
        .mclk(mclk), .rst_n(rst_n), .wr_en(we_pkwin), .wr_data(reg_wdata[7:0]), .q(pkwin_q));
    mcpr_cfg_reg #(.W(8), .RST(mcpr_pkg::RST_DIP_WIN)) u_dipwin (
        .mclk(mclk), .rst_n(rst_n), .wr_en(we_dipwin), .wr_data(reg_wdata[7:0]), .q(dipwin_q));
    mcpr_cfg_reg #(.W(8), .RST(mcpr_pkg::RST_PULSE_LATCH)) u_plat (
        .mclk(mclk), .rst_n(rst_n), .wr_en(we_plat), .wr_data(reg_wdata[7:0]), .q(plat_q));
    mcpr_cfg_reg #(.W(8), .RST(mcpr_pkg::RST_FAST_CAP)) u_fcap (
        .mclk(mclk), .rst_n(rst_n), .wr_en(we_fcap), .wr_data(reg_wdata[7:0]), .q(fcap_q));
    mcpr_cfg_reg #(.W(8), .RST(mcpr_pkg::RST_LP_OC_LVL)) u_lpoc (
        .mclk(mclk), .rst_n(rst_n), .wr_en(we_lpoc), .wr_data(reg_wdata[7:0]), .q(lpoc_q));
    mcpr_cfg_reg #(.W(8), .RST(mcpr_pkg::RST_LP1_SETUP)) u_lp1 (
        .mclk(mclk), .rst_n(rst_n), .wr_en(we_lp1), .wr_data(reg_wdata[7:0]), .q(lp1_q));

    assign pk.mag_a        = cur_mag_a;
    assign pk.mag_b        = cur_mag_b;
    assign pk.mag_c        = cur_mag_c;
    assign pk.sample_valid = cur_sample_valid;
    assign pk.half_cycle   = half_line_cycle;
    assign pk.window       = pkwin_q;

    mcpr_peak_capture u_peak (
        .mclk  (mclk),
        .rst_n (rst_n),
        .pk    (pk)
    );

    // read mux; unmapped and write-only slots return zero
    always_comb begin
        rdata_nxt = 32'h00000000;
        case (reg_addr)
            mcpr_pkg::ADDR_HPF_BYPASS:  rdata_nxt = {8'h00, hpf_q};
            mcpr_pkg::ADDR_CURRENT_PEAK_CAPTURE:       rdata_nxt = {5'h00, current_peak_capture_ph_r, current_peak_capture_val_r};
            mcpr_pkg::ADDR_CF1_DIV:     rdata_nxt = {16'h0000, cf1_q};
            mcpr_pkg::ADDR_CF2_DIV:     rdata_nxt = {16'h0000, cf2_q};
            mcpr_pkg::ADDR_CF3_DIV:     rdata_nxt = {16'h0000, cf3_q};
            mcpr_pkg::ADDR_TRIM_A:      rdata_nxt = {22'h000000, trim_a_q};
            mcpr_pkg::ADDR_TRIM_B:      rdata_nxt = {22'h000000, trim_b_q};
            mcpr_pkg::ADDR_TRIM_C:      rdata_nxt = {22'h000000, trim_c_q};
            mcpr_pkg::ADDR_SIGN:        rdata_nxt = {16'h0000, sign_r};
            mcpr_pkg::ADDR_GEN_SETUP:   rdata_nxt = {16'h0000, gen_q};
            mcpr_pkg::ADDR_MEAS_SETUP:  rdata_nxt = {24'h000000, meas_q};
            mcpr_pkg::ADDR_ACC_SETUP:   rdata_nxt = {24'h000000, acc_q};
            mcpr_pkg::ADDR_LINE_ACC:    rdata_nxt = {24'h000000, line_q};
            mcpr_pkg::ADDR_PEAK_WIN:    rdata_nxt = {24'h000000, pkwin_q};
            mcpr_pkg::ADDR_DIP_WIN:     rdata_nxt = {24'h000000, dipwin_q};
            mcpr_pkg::ADDR_PULSE_LATCH: rdata_nxt = {24'h000000, plat_q};
            mcpr_pkg::ADDR_FAST_CAP:    rdata_nxt = {24'h000000, fcap_q};
            mcpr_pkg::ADDR_REVISION:    rdata_nxt = {24'h000000, mcpr_pkg::DIE_REVISION};
            mcpr_pkg::ADDR_LP_OC_LVL:   rdata_nxt = {24'h000000, lpoc_q};
            mcpr_pkg::ADDR_LP1_SETUP:   rdata_nxt = {24'h000000, lp1_q};
            default:                    rdata_nxt = 32'h00000000;
        endcase
    end

    // read-only contents come only from measurement; no write strobe reaches them
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            current_peak_capture_val_r <= 24'h000000;
            current_peak_capture_ph_r  <= 3'h0;
            sign_r      <= 16'h0000;
        end else begin
            sign_r <= power_sign_in;
            if (pk.peak_update) begin
                current_peak_capture_val_r <= pk.peak_value;
                current_peak_capture_ph_r  <= pk.peak_phase;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pin_r     <= 1'b0;
            pin_oe_r  <= 1'b0;
            hpf_byp_r <= 1'b0;
            rdata_r   <= 32'h00000000;
            rvalid_r  <= 1'b0;
        end else begin
            pin_r     <= pin_nxt;
            pin_oe_r  <= spi_active;
            // one compare on all 24 stored bits: any nonzero bit bypasses all filters
            hpf_byp_r <= (hpf_q != 24'h000000);
            rvalid_r  <= reg_rd;
            if (reg_rd) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    assign reg_rdata                  = rdata_r;
    assign reg_rvalid                 = rvalid_r;
    assign select_or_capture_pin_o    = pin_r;
    assign select_or_capture_pin_oe   = pin_oe_r;
    assign highpass_bypass_en         = hpf_byp_r;
    assign pulse_out1_divider         = cf1_q;
    assign pulse_out2_divider         = cf2_q;
    assign pulse_out3_divider         = cf3_q;
    assign phase_a_delay_trim         = trim_a_q;
    assign phase_b_delay_trim         = trim_b_q;
    assign phase_c_delay_trim         = trim_c_q;
    assign general_setup              = gen_q;
    assign measurement_setup          = meas_q;
    assign accumulation_setup         = acc_q;
    assign line_accum_behavior        = line_q;
    assign peak_window_halfcycles     = pkwin_q;
    assign dip_window_halfcycles      = dipwin_q;
    assign pulses_per_energy_latch    = plat_q;
    assign fast_capture_port_setup    = fcap_q;
    assign lowpower_overcurrent_level = lpoc_q;
    assign lowpower1_setup            = lp1_q;
endmodule
`default_nettype wire

// [dv/mcpr_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module mcpr_monitor (
    // clock and reset
    input wire logic        mclk,
    input wire logic        rst_n,
    // register port
    input wire logic [15:0] reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic        reg_rvalid,
    // status and settings
    input wire logic [15:0] power_sign_in,
    input wire logic        spi_active,
    input wire logic        select_or_capture_pin_oe,
    input wire logic        highpass_bypass_en,
    input wire logic [7:0]  pulses_per_energy_latch,
    input wire logic [9:0]  phase_a_delay_trim
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_bypass_set_on: assert property (reg_wr && reg_addr == 16'h43B6
        && reg_wdata[23:0] != 24'h0
        ##1 !(reg_wr && reg_addr == 16'h43B6) |-> ##1 highpass_bypass_en)
        else $error("bypass not set");
    a_bypass_set_off: assert property (reg_wr && reg_addr == 16'h43B6
        && reg_wdata[23:0] == 24'h0
        ##1 !(reg_wr && reg_addr == 16'h43B6) |-> ##1 !highpass_bypass_en)
        else $error("bypass not cleared");
    a_latch_count_write: assert property (reg_wr && reg_addr == 16'hE705
        |=> pulses_per_energy_latch == $past(reg_wdata[7:0]))
        else $error("pulse latch count not written");
    a_trim_low_bits: assert property (reg_wr && reg_addr == 16'hE614
        |=> phase_a_delay_trim == $past(reg_wdata[9:0]))
        else $error("trim not written");
    // a request held into the last reset edge gets no answer
    a_read_answer_pulse: assert property ($past(rst_n)
        |-> reg_rvalid == $past(reg_rd))
        else $error("read answer not one cycle after request");
    a_peak_top_zero: assert property (reg_rvalid && $past(reg_addr) == 16'hE500
        |-> reg_rdata[31:27] == 5'h00)
        else $error("peak top bits not zero");
    a_trim_zero_pad: assert property (reg_rvalid && $past(reg_addr) == 16'hE614
        |-> reg_rdata[31:10] == 22'h0)
        else $error("trim readback not padded");
    // flags are sampled a cycle before the read is taken
    a_sign_readback: assert property (reg_rvalid && $past(reg_addr) == 16'hE617
        && $past(rst_n, 2) |-> reg_rdata == {16'h0000, $past(power_sign_in, 2)})
        else $error("sign flags readback wrong");
    a_pin_enable_follow: assert property ($past(rst_n)
        |-> select_or_capture_pin_oe == $past(spi_active))
        else $error("pin enable not following port state");
endmodule
bind mcpr_regbank mcpr_monitor mon (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .power_sign_in(power_sign_in), .spi_active(spi_active),
    .select_or_capture_pin_oe(select_or_capture_pin_oe),
    .highpass_bypass_en(highpass_bypass_en),
    .pulses_per_energy_latch(pulses_per_energy_latch),
    .phase_a_delay_trim(phase_a_delay_trim));
`default_nettype wire

// [dv/mcpr_host.sv]
`timescale 1ns/1ps
`default_nettype none
module mcpr_host (
    // clock
    input wire logic         mclk,
    // register port
    output var logic [15:0]  reg_addr,
    output var logic         reg_wr,
    output var logic         reg_rd,
    output var logic [31:0]  reg_wdata,
    input wire logic [31:0]  reg_rdata,
    input wire logic         reg_rvalid
);
    initial begin
        reg_addr = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 32'h00000000;
    end
    // one whole word per access; narrow registers take the low bits
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    // a missing answer turns into unknown so the caller's compare fails
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = (reg_rvalid === 1'b1) ? reg_rdata : 32'hXXXXXXXX;
    endtask
endmodule
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct {logic [15:0] a; logic [31:0] r; logic [31:0] e;} mcpr_row_t;
    logic        mclk, rst_n, sv, hl, spi, wr, rd, rv, en, pin, oe;
    logic [23:0] ma, mb, mc;
    logic [15:0] addr, sgn;
    logic [31:0] wd, rdat, d;
    logic [15:0] o16 [4];
    logic [9:0]  o10 [3];
    logic [7:0]  o8 [9];
    int          err_count = 0, num_checks = 0, cyc = 0;
    mcpr_row_t   rows [22];
    mcpr_host host (.mclk(mclk), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wd),
        .reg_rdata(rdat), .reg_rvalid(rv));
    mcpr_regbank dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
        .reg_wdata(wd), .reg_rdata(rdat), .reg_rvalid(rv), .cur_mag_a(ma), .cur_mag_b(mb),
        .cur_mag_c(mc), .cur_sample_valid(sv), .half_line_cycle(hl), .power_sign_in(sgn),
        .spi_active(spi), .select_or_capture_pin_o(pin), .select_or_capture_pin_oe(oe),
        .highpass_bypass_en(en), .pulse_out1_divider(o16[0]), .pulse_out2_divider(o16[1]),
        .pulse_out3_divider(o16[2]), .phase_a_delay_trim(o10[0]), .phase_b_delay_trim(o10[1]),
        .phase_c_delay_trim(o10[2]), .general_setup(o16[3]), .measurement_setup(o8[0]),
        .accumulation_setup(o8[1]), .line_accum_behavior(o8[2]), .peak_window_halfcycles(o8[3]),
        .dip_window_halfcycles(o8[4]), .pulses_per_energy_latch(o8[5]),
        .fast_capture_port_setup(o8[6]), .lowpower_overcurrent_level(o8[7]),
        .lowpower1_setup(o8[8]));
    task automatic summarize();
        if (err_count == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [31:0] e);
        host.rd(a, d);
        chk($sformatf("reg %h", a), e, d);
    endtask
    task automatic step(input logic [23:0] a, b, c, input logic h);
        @(posedge mclk);
        {ma, mb, mc, sv, hl} <= {a, b, c, 1'b1, h};
        @(posedge mclk);
        {sv, hl} <= 2'b00;
    endtask
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        // well above the roughly 185 cycles the sequence needs
        if (cyc == 3000) begin
            err_count++;
            summarize();
        end
    end
    initial begin
        {rst_n, sv, hl, spi, ma, mb, mc, sgn} = '0;
        rows = '{'{16'h43B6, 0, 32'hA5A5A5}, '{16'hE500, 0, 0}, '{16'hE611, 0, 32'hA5A5},
            '{16'hE612, 0, 32'hA5A5}, '{16'hE613, 0, 32'hA5A5}, '{16'hE614, 0, 32'h1A5},
            '{16'hE615, 0, 32'h1A5}, '{16'hE616, 0, 32'h1A5}, '{16'hE617, 0, 0},
            '{16'hE618, 0, 32'hA5A5}, '{16'hE700, 32'h1C, 32'hA5}, '{16'hE701, 0, 32'hA5},
            '{16'hE702, 32'h78, 32'hA5}, '{16'hE703, 0, 32'hA5}, '{16'hE704, 0, 32'hA5},
            '{16'hE705, 1, 32'hA5}, '{16'hE706, 0, 32'hA5}, '{16'hE707, 32'h5A, 32'h5A},
            '{16'hEBFF, 0, 0}, '{16'hEC00, 7, 32'hA5}, '{16'hEC01, 0, 32'hA5},
            '{16'h1234, 0, 0}};
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            rdchk(rows[i].a, rows[i].r);
            host.wr(rows[i].a, 32'hA5A5A5A5);
            rdchk(rows[i].a, rows[i].e);
        end
        // every setting output must carry what the loop wrote
        foreach (o16[i]) chk("setting out", 32'h0000A5A5, o16[i]);
        foreach (o10[i]) chk("trim out", 32'h000001A5, o10[i]);
        foreach (o8[i]) chk("setting out", 32'h000000A5, o8[i]);
        chk("bypass", 1, en);
        // only the low 24 bits count, so a top byte alone keeps filters on
        host.wr(16'h43B6, 32'hFF000000);
        repeat (2) @(posedge mclk);
        #1 chk("bypass", 0, en);
        host.wr(16'h43B6, 32'h00000001);
        repeat (2) @(posedge mclk);
        #1 chk("bypass", 1, en);
        host.wr(16'hEBFF, 1);
        #1 chk("pin", 0, pin);
        @(posedge mclk) spi <= 1'b1;
        host.wr(16'hEBFF, 1);
        #1 chk("pin", 1, pin);
        chk("pin enable", 1, oe);
        @(posedge mclk) sgn <= 16'hA5C3;
        rdchk(16'hE617, 32'h0000A5C3);
        host.wr(16'hE617, 0);
        rdchk(16'hE617, 32'h0000A5C3);
        host.wr(16'hE703, 2);
        step(10, 30, 30, 0);
        step(0, 0, 0, 1);
        step(5, 0, 0, 1);
        repeat (3) @(posedge mclk);
        rdchk(16'hE500, 32'h0600001E);
        step(24'h123456, 7, 7, 1);
        step(0, 0, 0, 1);
        repeat (3) @(posedge mclk);
        rdchk(16'hE500, 32'h01123456);
        @(posedge mclk) {rst_n, spi} <= 2'b00;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        rdchk(16'hE705, 32'h01);
        rdchk(16'hE702, 32'h78);
        rdchk(16'h43B6, 0);
        summarize();
    end
endmodule
`default_nettype wire
